// ==== design/tmc_mode_ctrl.sv ====
/*
  Operating-mode controller of a low-power CAN FD transceiver, with an Avalon-MM register slave.
  Assumes supply comparators, bus monitor and wake pin arrive as clean levels on i_sys_clk.
*/
// Summary of operation
// - Six modes chosen by pins, supplies and wake events.
// - Undervoltage timers stay disabled until their supply first rises above threshold.
// - Armed undervoltage lasting past persist time forces sleep.
// - Sleep-wake-error timer starts on standby entry, clears on normal entry.
// - Silent from standby keeps that timer running; silent from normal does not.
// - Timer expiry in standby or standby-entered silent forces sleep.
// - Sleep from go-to-sleep or undervoltage exits on standby pin rise; enable picks mode.
// - Pin-driven sleep exit only while io supply is above rising threshold.
// - Timeout sleep exits with standby pin high and an enable edge choosing mode.
// - Normal mode enables driver and receiver, receive output follows bus, inhibit on.
// - Silent mode disables driver, receiver follows bus, inhibit on.
// - Standby disables driver and receiver, runs bus monitor, receive low flags wake.
// - Go-to-sleep holds inhibit on, then after delay enters sleep, inhibit released.
// - Entering normal clears wake request and power-on flags.
// - Silent mode shows power-on and local failure on the fault output.
// - After a standby wake, normal mode reports the wake source on fault output.
// - Pending wake events turn a go-to-sleep request into standby until normal mode.
// - Sleep turns inhibit off, watches remote and local wake, exits on them.
// - Local wake monitor active in sleep, off in normal.
// - Remote wake needs dominant, recessive, dominant filtered within the wake timeout.
`timescale 1ns/10ps
module tmc_mode_ctrl #(
  parameter int unsigned P_INACTIVE_CYC = tmc_pkg::INACTIVE_CYC,
  parameter int unsigned P_UV_PERSIST_CYC = tmc_pkg::UV_PERSIST_CYC,
  parameter int unsigned P_WK_TIMEOUT_CYC = tmc_pkg::WK_TIMEOUT_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_en,
  input wire logic i_standby_ctrl_n,
  input wire tmc_pkg::tmc_supply_t i_supply,
  input wire logic i_bus_dominant,
  input wire logic i_bus_rx,
  input wire logic i_local_wake_pin,
  input wire logic i_local_failure,
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output tmc_pkg::tmc_mode_t o_mode,
  output tmc_pkg::tmc_xcvr_t o_xcvr,
  output logic o_receive_data_out,
  output logic o_supply_inhibit_output,
  output logic o_supply_inhibit_oe,
  output logic o_fault_indicator_n,
  output logic o_wake_request_flag,
  output logic o_power_on_flag
);

  localparam logic [tmc_pkg::CNT_W-1:0] INACT_LIM = tmc_pkg::CNT_W'(P_INACTIVE_CYC);
  localparam logic [tmc_pkg::CNT_W-1:0] UV_LIM = tmc_pkg::CNT_W'(P_UV_PERSIST_CYC);
  localparam logic [tmc_pkg::CNT_W-1:0] GTS_LIM = tmc_pkg::CNT_W'(tmc_pkg::SLEEP_ENTRY_CYC - 1);
  localparam logic [tmc_pkg::CNT_W-1:0] FILT_LIM = tmc_pkg::CNT_W'(tmc_pkg::WK_FILTER_CYC);
  localparam logic [tmc_pkg::CNT_W-1:0] WKTO_LIM = tmc_pkg::CNT_W'(P_WK_TIMEOUT_CYC - 1);
  localparam logic [1:0] PH_DOM1 = 2'h0;
  localparam logic [1:0] PH_REC = 2'h1;
  localparam logic [1:0] PH_DOM2 = 2'h2;

  typedef struct packed {
    tmc_pkg::tmc_mode_t mode;
    logic en_s1;
    logic en_s2;
    logic en_d;
    logic stb_s1;
    logic stb_s2;
    logic stb_d;
    logic lw_d;
    logic core_arm;
    logic io_arm;
    logic [tmc_pkg::CNT_W-1:0] core_cnt;
    logic [tmc_pkg::CNT_W-1:0] io_cnt;
    logic swe_run;
    logic [tmc_pkg::CNT_W-1:0] swe_cnt;
    logic [tmc_pkg::CNT_W-1:0] gts_cnt;
    logic sleep_swe;
    logic exit_ok;
    logic [1:0] wup_phase;
    logic [tmc_pkg::CNT_W-1:0] filt_cnt;
    logic [tmc_pkg::CNT_W-1:0] wk_cnt;
    logic wake_req;
    logic wake_local;
    logic pwr_on;
    logic rxd;
    logic fault_n;
    logic [1:0] ctrl;
    logic ack;
    logic [31:0] rdata;
  } tmc_state_t;

  tmc_state_t st_ff;
  tmc_state_t nxt_st;
  logic uv_exp;
  logic swe_exp;
  logic wup_ev;
  logic lw_ev;
  logic wake_ev;
  logic filt_match;
  logic en_rise;
  logic en_fall;
  logic stb_rise;
  logic lowpwr;

  function automatic logic [tmc_pkg::CNT_W-1:0] sat_inc(input logic [tmc_pkg::CNT_W-1:0] c,
                                                         input logic [tmc_pkg::CNT_W-1:0] lim);
    sat_inc = (c >= lim) ? lim : c + 1'b1;
  endfunction

  // Mode asked for by the pins while supplies are good
  function automatic tmc_pkg::tmc_mode_t pin_mode(input logic en, input logic stb, input logic pend);
    if (stb) begin
      pin_mode = en ? tmc_pkg::MD_NORMAL : tmc_pkg::MD_SILENT;
    end else if (en && !pend) begin
      pin_mode = tmc_pkg::MD_GOTOSLEEP;
    end else begin
      pin_mode = tmc_pkg::MD_STANDBY;
    end
  endfunction

  always_comb begin
    nxt_st = st_ff;
    nxt_st.en_s1 = i_en;
    nxt_st.en_s2 = st_ff.en_s1;
    nxt_st.en_d = st_ff.en_s2;
    nxt_st.stb_s1 = i_standby_ctrl_n;
    nxt_st.stb_s2 = st_ff.stb_s1;
    nxt_st.stb_d = st_ff.stb_s2;
    nxt_st.lw_d = i_local_wake_pin;
    en_rise = st_ff.en_s2 && !st_ff.en_d;
    en_fall = !st_ff.en_s2 && st_ff.en_d;
    stb_rise = st_ff.stb_s2 && !st_ff.stb_d;
    lowpwr = (st_ff.mode == tmc_pkg::MD_STANDBY) || (st_ff.mode == tmc_pkg::MD_GOTOSLEEP)
             || (st_ff.mode == tmc_pkg::MD_SLEEP);

    // Timers stay disarmed through a slow power-up ramp
    if (i_supply.core_above_rise) begin
      nxt_st.core_arm = 1'b1;
    end
    if (i_supply.io_above_rise) begin
      nxt_st.io_arm = 1'b1;
    end
    nxt_st.core_cnt = (st_ff.core_arm && i_supply.core_uv) ? sat_inc(st_ff.core_cnt, UV_LIM) : '0;
    nxt_st.io_cnt = (st_ff.io_arm && i_supply.io_uv) ? sat_inc(st_ff.io_cnt, UV_LIM) : '0;
    uv_exp = (st_ff.core_cnt >= UV_LIM) || (st_ff.io_cnt >= UV_LIM);

    swe_exp = st_ff.swe_run && (st_ff.swe_cnt >= INACT_LIM);
    if (st_ff.swe_run) begin
      nxt_st.swe_cnt = sat_inc(st_ff.swe_cnt, INACT_LIM);
    end
    nxt_st.gts_cnt = (st_ff.mode == tmc_pkg::MD_GOTOSLEEP) ? sat_inc(st_ff.gts_cnt, GTS_LIM) : '0;

    // Remote wake pattern detector
    wup_ev = 1'b0;
    filt_match = (st_ff.wup_phase == PH_REC) ? !i_bus_dominant : i_bus_dominant;
    if (!(lowpwr && st_ff.ctrl[tmc_pkg::CTRL_REMOTE_WAKE_EN])) begin
      nxt_st.wup_phase = PH_DOM1;
      nxt_st.filt_cnt = '0;
      nxt_st.wk_cnt = '0;
    end else begin
      nxt_st.filt_cnt = filt_match ? sat_inc(st_ff.filt_cnt, FILT_LIM) : '0;
      nxt_st.wk_cnt = (st_ff.wup_phase != PH_DOM1) ? sat_inc(st_ff.wk_cnt, WKTO_LIM) : '0;
      if (filt_match && st_ff.filt_cnt >= FILT_LIM) begin
        nxt_st.filt_cnt = '0;
        if (st_ff.wup_phase == PH_DOM2) begin
          wup_ev = 1'b1;
          nxt_st.wup_phase = PH_DOM1;
        end else begin
          nxt_st.wup_phase = st_ff.wup_phase + 2'h1;
        end
      end else if (st_ff.wup_phase != PH_DOM1 && st_ff.wk_cnt >= WKTO_LIM) begin
        // Pattern too slow: start again, which also needs a fresh filtered dominant
        nxt_st.wup_phase = PH_DOM1;
        nxt_st.filt_cnt = '0;
        nxt_st.wk_cnt = '0;
      end
    end
    lw_ev = lowpwr && st_ff.ctrl[tmc_pkg::CTRL_LOCAL_WAKE_EN] && (i_local_wake_pin != st_ff.lw_d);
    wake_ev = wup_ev || lw_ev;

    if (i_supply.battery_uv) begin
      nxt_st.mode = tmc_pkg::MD_PROTECTED;
    end else if (st_ff.mode == tmc_pkg::MD_PROTECTED) begin
      nxt_st.mode = tmc_pkg::MD_STANDBY;
      nxt_st.pwr_on = 1'b1;
    end else if (uv_exp && st_ff.mode != tmc_pkg::MD_SLEEP) begin
      nxt_st.mode = tmc_pkg::MD_SLEEP;
      nxt_st.sleep_swe = 1'b0;
    end else begin
      case (st_ff.mode)
        tmc_pkg::MD_SLEEP: begin
          if (wake_ev) begin
            nxt_st.mode = tmc_pkg::MD_STANDBY;
          end else if (i_supply.io_above_rise) begin
            if (!st_ff.sleep_swe) begin
              if (stb_rise) begin
                nxt_st.mode = st_ff.en_s2 ? tmc_pkg::MD_NORMAL : tmc_pkg::MD_SILENT;
              end
            end else if (!st_ff.stb_s2) begin
              if (en_rise || en_fall) begin
                nxt_st.exit_ok = 1'b1;
              end
            end else if (st_ff.exit_ok && en_rise) begin
              nxt_st.mode = tmc_pkg::MD_NORMAL;
            end else if (st_ff.exit_ok && en_fall) begin
              nxt_st.mode = tmc_pkg::MD_SILENT;
            end
          end
        end
        tmc_pkg::MD_GOTOSLEEP: begin
          nxt_st.mode = pin_mode(st_ff.en_s2, st_ff.stb_s2, st_ff.wake_req || wake_ev);
          if (nxt_st.mode == tmc_pkg::MD_GOTOSLEEP && st_ff.gts_cnt >= GTS_LIM) begin
            nxt_st.mode = tmc_pkg::MD_SLEEP;
            nxt_st.sleep_swe = 1'b0;
          end
        end
        default: begin
          if (swe_exp && (st_ff.mode == tmc_pkg::MD_STANDBY || st_ff.mode == tmc_pkg::MD_SILENT)) begin
            nxt_st.mode = tmc_pkg::MD_SLEEP;
            nxt_st.sleep_swe = 1'b1;
          end else if (i_supply.io_uv) begin
            nxt_st.mode = tmc_pkg::MD_STANDBY;
          end else begin
            nxt_st.mode = pin_mode(st_ff.en_s2, st_ff.stb_s2, st_ff.wake_req || wake_ev);
          end
        end
      endcase
    end

    // Mode entry effects
    if (nxt_st.mode != st_ff.mode) begin
      case (nxt_st.mode)
        tmc_pkg::MD_NORMAL: begin
          nxt_st.wake_req = 1'b0;
          nxt_st.pwr_on = 1'b0;
          nxt_st.swe_run = 1'b0;
          nxt_st.swe_cnt = '0;
        end
        tmc_pkg::MD_STANDBY: begin
          if (!st_ff.swe_run) begin
            nxt_st.swe_run = 1'b1;
            nxt_st.swe_cnt = '0;
          end
        end
        tmc_pkg::MD_SLEEP: begin
          nxt_st.swe_run = 1'b0;
          nxt_st.swe_cnt = '0;
          // A sleep begun with the pin already high needs the extra enable toggle
          nxt_st.exit_ok = !st_ff.stb_s2;
        end
        default: begin
          nxt_st.swe_run = st_ff.swe_run;
        end
      endcase
    end

    // Set wins over the normal-entry clear
    if (wake_ev) begin
      nxt_st.wake_req = 1'b1;
      nxt_st.wake_local = lw_ev;
    end

    case (nxt_st.mode)
      tmc_pkg::MD_NORMAL: begin
        nxt_st.rxd = i_bus_rx;
        nxt_st.fault_n = !st_ff.wake_local;
      end
      tmc_pkg::MD_SILENT: begin
        nxt_st.rxd = i_bus_rx;
        nxt_st.fault_n = !(nxt_st.pwr_on || i_local_failure);
      end
      default: begin
        nxt_st.rxd = !nxt_st.wake_req;
        nxt_st.fault_n = 1'b1;
      end
    endcase

    // Avalon slave: writes take effect at once, reads take one wait state
    nxt_st.ack = i_avs_read && !st_ff.ack;
    if (i_avs_read && !st_ff.ack) begin
      nxt_st.rdata = '0;
      if (i_avs_address == tmc_pkg::ADDR_CTRL) begin
        nxt_st.rdata[1:0] = st_ff.ctrl;
      end else if (i_avs_address == tmc_pkg::ADDR_STATUS) begin
        nxt_st.rdata[tmc_pkg::ST_MODE_LSB +: 3] = st_ff.mode;
        nxt_st.rdata[tmc_pkg::ST_WAKE_REQ] = st_ff.wake_req;
        nxt_st.rdata[tmc_pkg::ST_POWER_ON] = st_ff.pwr_on;
        nxt_st.rdata[tmc_pkg::ST_WAKE_LOCAL] = st_ff.wake_local;
        nxt_st.rdata[tmc_pkg::ST_SLEEP_SWE] = st_ff.sleep_swe;
        nxt_st.rdata[tmc_pkg::ST_SWE_RUN] = st_ff.swe_run;
      end
    end
    if (i_avs_write && i_avs_byteenable[0] && i_avs_address == tmc_pkg::ADDR_CTRL) begin
      nxt_st.ctrl = i_avs_writedata[1:0];
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      st_ff <= '0;
      st_ff.mode <= tmc_pkg::MD_STANDBY;
      st_ff.swe_run <= 1'b1;
      st_ff.pwr_on <= 1'b1;
      st_ff.rxd <= 1'b1;
      st_ff.fault_n <= 1'b1;
      st_ff.ctrl <= tmc_pkg::CTRL_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_avs_waitrequest = i_avs_read && !st_ff.ack;
  assign o_avs_readdata = st_ff.rdata;
  assign o_mode = st_ff.mode;
  assign o_xcvr.driver_en = (st_ff.mode == tmc_pkg::MD_NORMAL);
  assign o_xcvr.receiver_en = (st_ff.mode == tmc_pkg::MD_NORMAL) || (st_ff.mode == tmc_pkg::MD_SILENT);
  assign o_xcvr.bus_monitor_en = lowpwr;
  assign o_xcvr.local_wake_monitor_en = lowpwr && st_ff.ctrl[tmc_pkg::CTRL_LOCAL_WAKE_EN];
  assign o_receive_data_out = st_ff.rxd;
  assign o_supply_inhibit_output = 1'b1;
  assign o_supply_inhibit_oe = (st_ff.mode != tmc_pkg::MD_SLEEP) && (st_ff.mode != tmc_pkg::MD_PROTECTED);
  assign o_fault_indicator_n = st_ff.fault_n;
  assign o_wake_request_flag = st_ff.wake_req;
  assign o_power_on_flag = st_ff.pwr_on;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  property p_normal_clears;
    (st_ff.mode == tmc_pkg::MD_NORMAL) && ($past(st_ff.mode) != tmc_pkg::MD_NORMAL) |-> !st_ff.pwr_on;
  endproperty
  a_normal_clears: assert property (p_normal_clears) else $error("Power-on flag kept on normal entry");

  property p_swe_halt;
    (st_ff.mode == tmc_pkg::MD_NORMAL) |-> !st_ff.swe_run && (st_ff.swe_cnt == '0);
  endproperty
  a_swe_halt: assert property (p_swe_halt) else $error("Inactivity timer running in normal");

  property p_swe_sleep;
    (st_ff.mode == tmc_pkg::MD_SLEEP) && st_ff.sleep_swe && ($past(st_ff.mode) != tmc_pkg::MD_SLEEP)
      |-> $past(st_ff.swe_cnt) >= INACT_LIM;
  endproperty
  a_swe_sleep: assert property (p_swe_sleep) else $error("Timeout sleep without expiry");

  property p_uv_sleep;
    uv_exp && !i_supply.battery_uv && (st_ff.mode != tmc_pkg::MD_PROTECTED) |=> st_ff.mode == tmc_pkg::MD_SLEEP;
  endproperty
  a_uv_sleep: assert property (p_uv_sleep) else $error("Undervoltage persist did not sleep");

  property p_gts_delay;
    (st_ff.mode == tmc_pkg::MD_SLEEP) && ($past(st_ff.mode) == tmc_pkg::MD_GOTOSLEEP)
      |-> $past(st_ff.gts_cnt) >= GTS_LIM || $past(uv_exp);
  endproperty
  a_gts_delay: assert property (p_gts_delay) else $error("Go-to-sleep left early");

  property p_sleep_inh;
    (st_ff.mode == tmc_pkg::MD_SLEEP) |-> !o_supply_inhibit_oe && !o_xcvr.driver_en;
  endproperty
  a_sleep_inh: assert property (p_sleep_inh) else $error("Inhibit driven in sleep");

  property p_stb_exit;
    (st_ff.mode == tmc_pkg::MD_SLEEP) && !st_ff.sleep_swe && stb_rise && i_supply.io_above_rise && !wake_ev
      && !i_supply.battery_uv && !uv_exp
      |=> st_ff.mode == ($past(st_ff.en_s2) ? tmc_pkg::MD_NORMAL : tmc_pkg::MD_SILENT);
  endproperty
  a_stb_exit: assert property (p_stb_exit) else $error("Standby pin rise did not leave sleep");

  property p_normal_out;
    (st_ff.mode == tmc_pkg::MD_NORMAL) |-> o_xcvr.driver_en && o_xcvr.receiver_en && o_supply_inhibit_oe;
  endproperty
  a_normal_out: assert property (p_normal_out) else $error("Normal mode outputs wrong");

  property p_silent_out;
    (st_ff.mode == tmc_pkg::MD_SILENT) |-> !o_xcvr.driver_en && o_xcvr.receiver_en;
  endproperty
  a_silent_out: assert property (p_silent_out) else $error("Silent mode outputs wrong");

  c_wake: cover property ((st_ff.mode == tmc_pkg::MD_SLEEP) ##1 (st_ff.mode == tmc_pkg::MD_STANDBY));
  c_swe_sleep: cover property ((st_ff.mode == tmc_pkg::MD_SLEEP) && st_ff.sleep_swe);
  c_swe_exit: cover property (st_ff.sleep_swe && (st_ff.mode == tmc_pkg::MD_SLEEP)
                              ##1 (st_ff.mode == tmc_pkg::MD_NORMAL));

endmodule // tmc_mode_ctrl

// ==== design/tmc_pkg.sv ====
/*
  Package of the transceiver mode controller: modes, carrier structs, register map and timing constants.
  Assumes a 20 MHz system clock; all counts are derived from times at that rate.
*/
package tmc_pkg;

  typedef enum logic [2:0] {
    MD_NORMAL,
    MD_SILENT,
    MD_STANDBY,
    MD_GOTOSLEEP,
    MD_SLEEP,
    MD_PROTECTED
  } tmc_mode_t;

  // Supply comparator results, all active high
  typedef struct packed {
    logic battery_uv;
    logic core_above_rise;
    logic core_uv;
    logic io_above_rise;
    logic io_uv;
  } tmc_supply_t;

  // Analog block enables
  typedef struct packed {
    logic driver_en;
    logic receiver_en;
    logic bus_monitor_en;
    logic local_wake_monitor_en;
  } tmc_xcvr_t;

  localparam int unsigned CLK_MHZ = 20;
  localparam int unsigned CNT_W = 32;

  localparam int unsigned INACTIVE_TIME_US = 1000000;
  localparam int unsigned UV_PERSIST_TIME_US = 200000;
  localparam int unsigned SLEEP_ENTRY_DELAY_US = 20;
  localparam int unsigned WK_FILTER_TIME_NS = 1000;
  localparam int unsigned WK_TIMEOUT_TIME_US = 1000;

  localparam int unsigned INACTIVE_CYC = INACTIVE_TIME_US * CLK_MHZ;
  localparam int unsigned UV_PERSIST_CYC = UV_PERSIST_TIME_US * CLK_MHZ;
  localparam int unsigned SLEEP_ENTRY_CYC = SLEEP_ENTRY_DELAY_US * CLK_MHZ;
  localparam int unsigned WK_FILTER_CYC = (WK_FILTER_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned WK_TIMEOUT_CYC = WK_TIMEOUT_TIME_US * CLK_MHZ;

  // Register map, byte addresses
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam int unsigned CTRL_REMOTE_WAKE_EN = 0;
  localparam int unsigned CTRL_LOCAL_WAKE_EN = 1;
  localparam logic [1:0] CTRL_RESET = 2'h3;
  localparam int unsigned ST_MODE_LSB = 0;
  localparam int unsigned ST_WAKE_REQ = 3;
  localparam int unsigned ST_POWER_ON = 4;
  localparam int unsigned ST_WAKE_LOCAL = 5;
  localparam int unsigned ST_SLEEP_SWE = 6;
  localparam int unsigned ST_SWE_RUN = 7;

endpackage

// ==== verif/tmc_host_model.sv ====
/*
  Host controller model: drives the enable and standby control pins of the mode controller.
  Assumes one clock; the bench calls its tasks just after a rising edge.
*/
`timescale 1ns/10ps
module tmc_host_model #(
  parameter int P_SETUP_CYC = 10
) (
  input wire logic i_sys_clk,
  output logic o_en,
  output logic o_standby_ctrl_n
);
  initial begin
    o_en = 1'b0;
    o_standby_ctrl_n = 1'b0;
  end

  // Pins change just after a rising edge, at most once per edge
  task automatic set_pins(input logic e, input logic s);
    @(posedge i_sys_clk);
    o_en <= e;
    o_standby_ctrl_n <= s;
  endtask

  // One of the first two steps is an enable edge while standby is low, whatever enable was
  task automatic exit_timeout_sleep(input logic e_final);
    set_pins(e_final, 1'b0);
    set_pins(~e_final, 1'b0);
    repeat (P_SETUP_CYC) @(posedge i_sys_clk);
    set_pins(~e_final, 1'b1);
    set_pins(e_final, 1'b1);
  endtask
endmodule // tmc_host_model

// ==== verif/testbench.sv ====
/*
  Self-checking bench of the mode controller: row table of pin modes, then hand-written cases.
  Assumes the host model drives the pins and short timer parameters keep the run brief.
*/
`timescale 1ns/10ps
module testbench;
  localparam int SETUP_CYC = 10;
  typedef struct packed {
    logic en;
    logic stb_n;
    logic rx;
    tmc_pkg::tmc_mode_t md;
    logic [2:0] xc;
    logic rxd;
  } tmc_row_t;
  logic i_sys_clk, i_rst, en, stb_n, bus_dominant, bus_rx, local_wake_pin, local_failure;
  logic avs_read, avs_write, waitreq, rxd, supply_inhibit_output, inh_oe, fault_n, wake_req, pwr_on;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  tmc_pkg::tmc_supply_t supply;
  tmc_pkg::tmc_mode_t mode;
  tmc_pkg::tmc_xcvr_t xcvr;
  tmc_row_t rows [5];
  int bad_count = 0;
  int samples_checked = 0;

  tmc_host_model #(.P_SETUP_CYC(SETUP_CYC)) host (.i_sys_clk(i_sys_clk), .o_en(en), .o_standby_ctrl_n(stb_n));

  tmc_mode_ctrl #(.P_INACTIVE_CYC(50), .P_UV_PERSIST_CYC(20), .P_WK_TIMEOUT_CYC(200)) dut (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_en(en), .i_standby_ctrl_n(stb_n), .i_supply(supply),
    .i_bus_dominant(bus_dominant), .i_bus_rx(bus_rx), .i_local_wake_pin(local_wake_pin),
    .i_local_failure(local_failure), .i_avs_address(avs_address), .i_avs_read(avs_read),
    .i_avs_write(avs_write), .i_avs_writedata(avs_writedata), .i_avs_byteenable(4'hf),
    .o_avs_readdata(avs_readdata), .o_avs_waitrequest(waitreq), .o_mode(mode), .o_xcvr(xcvr),
    .o_receive_data_out(rxd), .o_supply_inhibit_output(supply_inhibit_output), .o_supply_inhibit_oe(inh_oe),
    .o_fault_indicator_n(fault_n), .o_wake_request_flag(wake_req), .o_power_on_flag(pwr_on));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask

  // No fixed latency assumed: wait for waitrequest low, the watchdog bounds a hang
  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= d;
    do begin
      @(posedge i_sys_clk);
    end while (waitreq !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge i_sys_clk);
  endtask

  task automatic endt(input string s);
    $display("test %s finished", s);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    i_sys_clk = 1'b0;
    forever #25 i_sys_clk = ~i_sys_clk;
  end

  initial begin
    repeat (20000) @(posedge i_sys_clk);
    bad_count++;
    test_done();
  end

  initial begin
    i_rst = 1'b1;
    bus_dominant = 1'b0;
    bus_rx = 1'b0;
    local_wake_pin = 1'b0;
    local_failure = 1'b0;
    supply = 5'h0a;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    rows[0] = '{1'b1, 1'b1, 1'b1, tmc_pkg::MD_NORMAL, 3'h6, 1'b1};
    rows[1] = '{1'b0, 1'b1, 1'b0, tmc_pkg::MD_SILENT, 3'h2, 1'b0};
    rows[2] = '{1'b1, 1'b1, 1'b0, tmc_pkg::MD_NORMAL, 3'h6, 1'b0};
    rows[3] = '{1'b0, 1'b0, 1'b0, tmc_pkg::MD_STANDBY, 3'h1, 1'b1};
    rows[4] = '{1'b1, 1'b1, 1'b1, tmc_pkg::MD_NORMAL, 3'h6, 1'b1};
    cyc(4);
    i_rst <= 1'b0;
    cyc(2);
    chk(mode, tmc_pkg::MD_STANDBY);
    chk({pwr_on, wake_req, rxd, fault_n, inh_oe}, 5'h17);
    chk(supply_inhibit_output, 1'b1);
    av(1'b0, tmc_pkg::ADDR_STATUS, 32'h0);
    chk(rd & 32'h9f, 32'h92);
    endt("reset");
    foreach (rows[i]) begin
      bus_rx <= rows[i].rx;
      host.set_pins(rows[i].en, rows[i].stb_n);
      cyc(6);
      chk(mode, rows[i].md);
      chk(xcvr[3:1], rows[i].xc);
      chk(xcvr[0], rows[i].md == tmc_pkg::MD_STANDBY);
      chk(rxd, rows[i].rxd);
      chk(inh_oe, 1'b1);
    end
    chk(pwr_on, 1'b0);
    endt("pin_table");
    av(1'b0, tmc_pkg::ADDR_CTRL, 32'h0);
    chk(rd, 32'(tmc_pkg::CTRL_RESET));
    av(1'b1, tmc_pkg::ADDR_CTRL, 32'h0);
    av(1'b0, tmc_pkg::ADDR_CTRL, 32'h0);
    chk(rd, 32'h0);
    av(1'b0, 4'h8, 32'h0);
    chk(rd, 32'h0);
    av(1'b1, tmc_pkg::ADDR_CTRL, 32'h3);
    av(1'b0, tmc_pkg::ADDR_STATUS, 32'h0);
    chk(rd & 32'h9f, 32'h0);
    endt("registers");
    host.set_pins(1'b1, 1'b0);
    cyc(6);
    chk({mode, inh_oe}, {tmc_pkg::MD_GOTOSLEEP, 1'b1});
    cyc(tmc_pkg::SLEEP_ENTRY_CYC - 20);
    chk(mode, tmc_pkg::MD_GOTOSLEEP);
    cyc(40);
    chk({mode, inh_oe, xcvr[0]}, {tmc_pkg::MD_SLEEP, 2'b01});
    supply.io_above_rise <= 1'b0;
    host.set_pins(1'b1, 1'b1);
    cyc(6);
    chk(mode, tmc_pkg::MD_SLEEP);
    host.set_pins(1'b1, 1'b0);
    supply.io_above_rise <= 1'b1;
    cyc(3);
    host.set_pins(1'b1, 1'b1);
    cyc(6);
    chk({mode, inh_oe}, {tmc_pkg::MD_NORMAL, 1'b1});
    endt("go_to_sleep");
    host.set_pins(1'b1, 1'b0);
    cyc(450);
    local_wake_pin <= 1'b1;
    cyc(6);
    chk({mode, wake_req, rxd}, {tmc_pkg::MD_STANDBY, 2'b10});
    cyc(20);
    chk(mode, tmc_pkg::MD_STANDBY);
    host.set_pins(1'b1, 1'b1);
    cyc(6);
    chk({mode, wake_req, fault_n}, {tmc_pkg::MD_NORMAL, 2'b00});
    endt("local_wake");
    host.set_pins(1'b0, 1'b0);
    cyc(6);
    chk(mode, tmc_pkg::MD_STANDBY);
    cyc(60);
    chk(mode, tmc_pkg::MD_SLEEP);
    host.set_pins(1'b0, 1'b1);
    cyc(6);
    chk(mode, tmc_pkg::MD_SLEEP);
    host.set_pins(1'b1, 1'b1);
    cyc(6);
    chk(mode, tmc_pkg::MD_NORMAL);
    endt("swe_timeout");
    local_failure <= 1'b1;
    host.set_pins(1'b0, 1'b1);
    cyc(80);
    chk({mode, fault_n}, {tmc_pkg::MD_SILENT, 1'b0});
    host.set_pins(1'b0, 1'b0);
    cyc(6);
    host.set_pins(1'b0, 1'b1);
    cyc(70);
    chk(mode, tmc_pkg::MD_SLEEP);
    host.exit_timeout_sleep(1'b0);
    cyc(6);
    chk(mode, tmc_pkg::MD_SILENT);
    local_failure <= 1'b0;
    endt("silent_swe");
    host.set_pins(1'b1, 1'b1);
    cyc(6);
    supply.core_uv <= 1'b1;
    cyc(8);
    chk(mode, tmc_pkg::MD_NORMAL);
    cyc(20);
    chk(mode, tmc_pkg::MD_SLEEP);
    supply.core_uv <= 1'b0;
    host.set_pins(1'b1, 1'b0);
    // Two half patterns, each cut off by the wake timeout
    for (int k = 0; k < 2; k++) begin
      bus_dominant <= 1'b1;
      cyc(25);
      bus_dominant <= 1'b0;
      cyc(250);
    end
    chk(mode, tmc_pkg::MD_SLEEP);
    for (int k = 0; k < 3; k++) begin
      bus_dominant <= (k != 1);
      cyc(25);
    end
    bus_dominant <= 1'b0;
    cyc(6);
    chk({mode, wake_req, rxd}, {tmc_pkg::MD_STANDBY, 2'b10});
    host.set_pins(1'b1, 1'b1);
    cyc(6);
    chk({mode, fault_n}, {tmc_pkg::MD_NORMAL, 1'b1});
    endt("uv_remote_wake");
    // Battery loss overrides everything; on return the pins take over one edge later
    supply.battery_uv <= 1'b1;
    cyc(3);
    chk({mode, inh_oe}, {tmc_pkg::MD_PROTECTED, 1'b0});
    supply.battery_uv <= 1'b0;
    cyc(2);
    chk({mode, pwr_on, inh_oe}, {tmc_pkg::MD_STANDBY, 2'b11});
    endt("protected");
    test_done();
  end
endmodule // testbench
